// ---- charger_fault_pkg.sv ----
// Package with constants, register map and carrier types for the charger fault block
package charger_fault_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned OVERLOAD_TIME_MS = 30;
  localparam int unsigned OVERLOAD_CYCLES = (CLK_HZ / 1000) * OVERLOAD_TIME_MS;
  localparam int unsigned OVL_CNT_W = 21;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] MODE_OFFSET = 8'h04;
  localparam logic [7:0] STATUS_OFFSET = 8'h08;
  localparam logic [7:0] MASK_OFFSET = 8'h0C;
  localparam logic [7:0] STATE_OFFSET = 8'h10;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int unsigned IND_SEL_LSB = 0;
  localparam int unsigned MODE_BOOST_BIT = 0;
  localparam int unsigned MODE_CHARGE_BIT = 1;
  localparam logic [1:0] IND_SEL_RESET = 2'h0;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [4:0] MASK_RESET = 5'h00;
  localparam logic [1:0] IND_CHARGING = 2'h0;
  localparam logic [1:0] IND_LOW = 2'h1;
  localparam logic [1:0] IND_HIZ = 2'h2;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic boost_battery_undervoltage_flag;
    logic boost_battery_overvoltage_flag;
    logic charge_battery_overvoltage_flag;
    logic boost_overload_flag;
    logic boost_output_overvoltage_flag;
  } fault_flags_t;

  typedef struct packed {
    logic vin_over_ovp;
    logic inductor_at_limit;
    logic bat_over_ovp;
    logic bat_below_release;
    logic bat_over_max;
    logic bat_below_run_min;
    logic bat_below_start_min;
  } analog_cmp_t;

  typedef enum logic [1:0] {
    PWR_IDLE,
    PWR_CHARGE,
    PWR_BOOST,
    PWR_HIZ
  } power_state_t;

endpackage

// ---- sync_2ff.sv ----
// Two-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/10ps
module sync_2ff #(
  parameter int unsigned WIDTH = 7
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;

endmodule

// ---- charger_fault_protection.sv ----
// Fault protection, status indicator and register slave of the charger
`timescale 1ns/10ps
module charger_fault_protection
  import charger_fault_pkg::*;
#(
  parameter int unsigned OVERLOAD_LIMIT = OVERLOAD_CYCLES
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic supply_input_pin_ovp_i,
  input wire logic inductor_limit_i,
  input wire logic battery_sense_pin_ovp_i,
  input wire logic battery_sense_pin_release_i,
  input wire logic battery_sense_pin_max_i,
  input wire logic battery_sense_pin_run_min_i,
  input wire logic battery_sense_pin_start_min_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic switching_en_o,
  output logic charging_o,
  output logic hiz_o,
  output logic indicator_o,
  output logic indicator_oe_o,
  output logic irq_n_o
);

  // ****************************************************************
  // Input synchronisation
  // ****************************************************************
  analog_cmp_t cmp_raw;
  analog_cmp_t cmp;

  assign cmp_raw = '{vin_over_ovp: supply_input_pin_ovp_i,
                     inductor_at_limit: inductor_limit_i,
                     bat_over_ovp: battery_sense_pin_ovp_i,
                     bat_below_release: battery_sense_pin_release_i,
                     bat_over_max: battery_sense_pin_max_i,
                     bat_below_run_min: battery_sense_pin_run_min_i,
                     bat_below_start_min: battery_sense_pin_start_min_i};

  sync_2ff #(.WIDTH(7)) u_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .async_i(cmp_raw),
    .sync_o(cmp)
  );

  // ****************************************************************
  // State
  // ****************************************************************
  power_state_t state_reg, state_next;
  logic [1:0] ind_sel_reg, ind_sel_next;
  logic [1:0] mode_reg, mode_next;
  fault_flags_t status_reg, status_next;
  fault_flags_t mask_reg, mask_next;
  logic bat_ov_active_reg, bat_ov_active_next;
  logic boost_started_reg, boost_started_next;
  logic [OVL_CNT_W-1:0] ovl_cnt_reg, ovl_cnt_next;
  logic aw_hold_reg, aw_hold_next;
  logic w_hold_reg, w_hold_next;
  logic [7:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic switching_reg, switching_next;
  logic charging_reg, charging_next;
  logic hiz_reg, hiz_next;
  logic ind_oe_reg, ind_oe_next;
  logic irq_n_reg, irq_n_next;

  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == CTRL_OFFSET) || (a == MODE_OFFSET) || (a == STATUS_OFFSET) ||
                  (a == MASK_OFFSET) || (a == STATE_OFFSET);
  endfunction

  // ****************************************************************
  // Fault detection and power state
  // ****************************************************************
  fault_flags_t events;
  logic overload_trip;
  logic do_write;
  logic do_read;
  logic reg_reset;
  logic [31:0] rd_word;

  always_comb begin
    events = '0;
    overload_trip = 1'b0;
    ovl_cnt_next = '0;
    state_next = state_reg;
    bat_ov_active_next = bat_ov_active_reg;
    boost_started_next = boost_started_reg;
    unique case (state_reg)
      PWR_IDLE: begin
        if (mode_reg[MODE_BOOST_BIT]) begin
          state_next = PWR_BOOST;
          boost_started_next = 1'b0;
        end else if (mode_reg[MODE_CHARGE_BIT]) begin
          state_next = PWR_CHARGE;
        end
      end
      PWR_CHARGE: begin
        if (bat_ov_active_reg) begin
          if (cmp.bat_below_release) begin
            bat_ov_active_next = 1'b0;
          end
        end else if (cmp.bat_over_ovp) begin
          bat_ov_active_next = 1'b1;
          events.charge_battery_overvoltage_flag = 1'b1;
        end
        if (!mode_reg[MODE_CHARGE_BIT] && !bat_ov_active_reg) begin
          state_next = PWR_IDLE;
        end
      end
      PWR_BOOST: begin
        boost_started_next = 1'b1;
        if (cmp.inductor_at_limit) begin
          ovl_cnt_next = ovl_cnt_reg + OVL_CNT_W'(1);
          if (ovl_cnt_reg >= OVL_CNT_W'(OVERLOAD_LIMIT)) begin
            overload_trip = 1'b1;
            events.boost_overload_flag = 1'b1;
            ovl_cnt_next = '0;
          end
        end
        if (cmp.vin_over_ovp) begin
          events.boost_output_overvoltage_flag = 1'b1;
          state_next = PWR_HIZ;
        end else if (cmp.bat_over_max) begin
          events.boost_battery_overvoltage_flag = 1'b1;
          state_next = PWR_HIZ;
        end else if (boost_started_reg ? cmp.bat_below_run_min : cmp.bat_below_start_min) begin
          events.boost_battery_undervoltage_flag = 1'b1;
          state_next = PWR_HIZ;
        end else if (overload_trip) begin
          state_next = PWR_IDLE;
        end else if (!mode_reg[MODE_BOOST_BIT]) begin
          state_next = PWR_IDLE;
        end
      end
      PWR_HIZ: begin
        if (!mode_reg[MODE_BOOST_BIT]) begin
          state_next = PWR_IDLE;
        end
      end
    endcase
  end

  // Overload restores control, mode and mask defaults; battery over-voltage release restores control and mask only
  assign reg_reset = overload_trip ||
                     (state_reg == PWR_CHARGE && bat_ov_active_reg && cmp.bat_below_release);

  // ****************************************************************
  // Register bus
  // ****************************************************************
  assign do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign do_read = s_axi_arvalid_i && !rvalid_reg;

  always_comb begin
    rd_word = '0;
    unique case (s_axi_araddr_i)
      CTRL_OFFSET: rd_word[1:0] = ind_sel_reg;
      MODE_OFFSET: rd_word[1:0] = mode_reg;
      STATUS_OFFSET: rd_word[4:0] = status_reg;
      MASK_OFFSET: rd_word[4:0] = mask_reg;
      STATE_OFFSET: rd_word[3:0] = {bat_ov_active_reg, hiz_reg, charging_reg, switching_reg};
      default: rd_word = '0;
    endcase
  end

  always_comb begin
    aw_hold_next = aw_hold_reg;
    w_hold_next = w_hold_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg && !s_axi_bready_i;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg && !s_axi_rready_i;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    ind_sel_next = ind_sel_reg;
    mode_next = mode_reg;
    mask_next = mask_reg;
    status_next = status_reg;
    if (s_axi_awvalid_i && !aw_hold_reg) begin
      aw_hold_next = 1'b1;
      awaddr_next = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && !w_hold_reg) begin
      w_hold_next = 1'b1;
      wdata_next = s_axi_wdata_i;
      wstrb_next = s_axi_wstrb_i;
    end
    if (do_write) begin
      aw_hold_next = 1'b0;
      w_hold_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = addr_mapped(awaddr_reg) ? AXI_OKAY : AXI_SLVERR;
      if (wstrb_reg[0]) begin
        unique case (awaddr_reg)
          CTRL_OFFSET: ind_sel_next = wdata_reg[1:0];
          MODE_OFFSET: mode_next = wdata_reg[1:0];
          STATUS_OFFSET: status_next = status_reg & ~fault_flags_t'(wdata_reg[4:0]);
          MASK_OFFSET: mask_next = wdata_reg[4:0];
          default: ;
        endcase
      end
    end
    if (do_read) begin
      rvalid_next = 1'b1;
      rdata_next = rd_word;
      rresp_next = addr_mapped(s_axi_araddr_i) ? AXI_OKAY : AXI_SLVERR;
    end
    // Set wins over a simultaneous write-one clear
    status_next = status_next | events;
    if (reg_reset) begin
      ind_sel_next = IND_SEL_RESET;
      mode_next = overload_trip ? MODE_RESET : mode_next;
      mask_next = MASK_RESET;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  always_comb begin
    switching_next = (state_next == PWR_BOOST) ||
                     (state_next == PWR_CHARGE && !bat_ov_active_next);
    charging_next = (state_next == PWR_CHARGE) && !bat_ov_active_next;
    hiz_next = (state_next == PWR_HIZ);
    unique case (ind_sel_next)
      IND_CHARGING: ind_oe_next = charging_next;
      IND_LOW: ind_oe_next = 1'b1;
      IND_HIZ: ind_oe_next = 1'b0;
      default: ind_oe_next = 1'b0;
    endcase
    irq_n_next = ~|(status_next & mask_next);
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= PWR_IDLE;
      ind_sel_reg <= IND_SEL_RESET;
      mode_reg <= MODE_RESET;
      status_reg <= '0;
      mask_reg <= MASK_RESET;
      bat_ov_active_reg <= 1'b0;
      boost_started_reg <= 1'b0;
      ovl_cnt_reg <= '0;
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      bvalid_reg <= 1'b0;
      bresp_reg <= AXI_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= AXI_OKAY;
      switching_reg <= 1'b0;
      charging_reg <= 1'b0;
      hiz_reg <= 1'b0;
      ind_oe_reg <= 1'b0;
      irq_n_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      ind_sel_reg <= ind_sel_next;
      mode_reg <= mode_next;
      status_reg <= status_next;
      mask_reg <= mask_next;
      bat_ov_active_reg <= bat_ov_active_next;
      boost_started_reg <= boost_started_next;
      ovl_cnt_reg <= ovl_cnt_next;
      aw_hold_reg <= aw_hold_next;
      w_hold_reg <= w_hold_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      switching_reg <= switching_next;
      charging_reg <= charging_next;
      hiz_reg <= hiz_next;
      ind_oe_reg <= ind_oe_next;
      irq_n_reg <= irq_n_next;
    end
  end

  assign s_axi_awready_o = !aw_hold_reg;
  assign s_axi_wready_o = !w_hold_reg;
  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o = bresp_reg;
  assign s_axi_arready_o = !rvalid_reg;
  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rdata_o = rdata_reg;
  assign s_axi_rresp_o = rresp_reg;
  assign switching_en_o = switching_reg;
  assign charging_o = charging_reg;
  assign hiz_o = hiz_reg;
  assign indicator_o = 1'b0;
  assign indicator_oe_o = ind_oe_reg;
  assign irq_n_o = irq_n_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_boost_vin_ovp: assert property ((state_reg == PWR_BOOST && cmp.vin_over_ovp) |=>
    (hiz_o && !switching_en_o && status_reg.boost_output_overvoltage_flag))
    else $error("Boost output over-voltage not handled");
  a_overload_reset: assert property ((state_reg == PWR_BOOST && overload_trip) |=>
    (status_reg.boost_overload_flag && mode_reg == MODE_RESET && ind_sel_reg == IND_SEL_RESET))
    else $error("Boost overload did not reset registers");
  a_overload_time: assert property (overload_trip |->
    (state_reg == PWR_BOOST && cmp.inductor_at_limit && ovl_cnt_reg >= OVL_CNT_W'(OVERLOAD_LIMIT)))
    else $error("Overload declared too early");
  a_ind_charging: assert property ((ind_sel_reg == IND_CHARGING) |->
    (indicator_oe_o == charging_o))
    else $error("Indicator does not follow charging");
  a_ind_fixed: assert property ((ind_sel_reg == IND_LOW) |-> indicator_oe_o)
    else $error("Indicator not held low");
  a_ind_hiz: assert property ((ind_sel_reg == IND_HIZ) |-> !indicator_oe_o)
    else $error("Indicator not high impedance");
  a_bat_ovp_stop: assert property ((state_reg == PWR_CHARGE && !bat_ov_active_reg &&
    cmp.bat_over_ovp) |=> (!charging_o && status_reg.charge_battery_overvoltage_flag))
    else $error("Battery over-voltage not handled");
  a_irq_level: assert property (irq_n_o == !(|(status_reg & mask_reg)))
    else $error("Interrupt level wrong");
  a_bat_ovp_release: assert property ((state_reg == PWR_CHARGE && bat_ov_active_reg &&
    cmp.bat_below_release) |=> (!bat_ov_active_reg && ind_sel_reg == IND_SEL_RESET))
    else $error("Battery over-voltage not released");
  a_boost_bat_range: assert property ((state_reg == PWR_BOOST && cmp.bat_over_max) |=>
    (hiz_o && status_reg.boost_battery_overvoltage_flag))
    else $error("Boost battery over-voltage not handled");
  a_mode_gate: assert property ((state_reg != PWR_BOOST) |=>
    !$rose(status_reg.boost_output_overvoltage_flag))
    else $error("Boost fault outside boost mode");

  c_boost_ovp: cover property (state_reg == PWR_BOOST ##1 hiz_o);
  c_overload: cover property (overload_trip);
  c_bat_ovp_cycle: cover property (bat_ov_active_reg ##[1:20] !bat_ov_active_reg);
  c_irq: cover property (!irq_n_o);

endmodule

// ---- charger_fault_protection_tb_top.sv ----
// Self-checking testbench for the charger fault protection block
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin mismatches++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module charger_fault_protection_tb_top;
  import charger_fault_pkg::*;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic clk_i;
  logic reset_i;
  analog_cmp_t cmp;
  logic [7:0] awaddr;
  logic [7:0] araddr;
  logic awvalid;
  logic wvalid;
  logic bready;
  logic arvalid;
  logic rready;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic awready;
  logic wready;
  logic bvalid;
  logic arready;
  logic rvalid;
  logic [1:0] bresp;
  logic [1:0] rresp;
  logic [31:0] rdata;
  logic sw;
  logic chg;
  logic hiz;
  logic ind;
  logic ind_oe;
  logic irq_n;
  int mismatches;
  int samples_checked;
  int seed;
  logic [31:0] rd;
  logic [1:0] rsp;
  logic [1:0] sel;
  logic c;
  logic [6:0] fv[4] = '{7'h48, 7'h0c, 7'h0a, 7'h09};
  logic [31:0] fb[4] = '{32'h0000_0001, 32'h0000_0008, 32'h0000_0010, 32'h0000_0010};
  logic [7:0] offs[5] = '{CTRL_OFFSET, MODE_OFFSET, STATUS_OFFSET, MASK_OFFSET, STATE_OFFSET};
  // Shortened overload hold time keeps the run brief
  localparam int unsigned OVL_TEST = 4000;

  charger_fault_protection #(
    .OVERLOAD_LIMIT(OVL_TEST)
  ) uut (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .supply_input_pin_ovp_i(cmp.vin_over_ovp),
    .inductor_limit_i(cmp.inductor_at_limit),
    .battery_sense_pin_ovp_i(cmp.bat_over_ovp),
    .battery_sense_pin_release_i(cmp.bat_below_release),
    .battery_sense_pin_max_i(cmp.bat_over_max),
    .battery_sense_pin_run_min_i(cmp.bat_below_run_min),
    .battery_sense_pin_start_min_i(cmp.bat_below_start_min),
    .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb),
    .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready),
    .switching_en_o(sw),
    .charging_o(chg),
    .hiz_o(hiz),
    .indicator_o(ind),
    .indicator_oe_o(ind_oe),
    .irq_n_o(irq_n)
  );

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic wrap_up();
    $display("Counts: mismatches %0d, samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [1:0] r);
    int n;
    logic done;
    @(posedge clk_i);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    done = 1'b0;
    n = 0;
    r = 2'h3;
    while (!done) begin
      @(posedge clk_i);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) begin
        bready <= 1'b0;
        r = bresp;
        done = 1'b1;
      end else if (n > 50) begin
        mismatches++;
        $display("Error write response expected bvalid seen none");
        wrap_up();
      end
    end
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic done;
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    done = 1'b0;
    n = 0;
    d = 32'h0000_0000;
    r = 2'h3;
    while (!done) begin
      @(posedge clk_i);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rready && rvalid) begin
        rready <= 1'b0;
        d = rdata;
        r = rresp;
        done = 1'b1;
      end else if (n > 50) begin
        mismatches++;
        $display("Error read response expected rvalid seen none");
        wrap_up();
      end
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, 4'hf, r);
    `CHK("bresp", AXI_OKAY, r)
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    `CHK("rresp", AXI_OKAY, r)
    `CHK($sformatf("register %h", a), e, d)
  endtask

  // Indicator pulls low for select 00 while charging, always for 01
  function automatic logic ind_exp(input logic [1:0] s, input logic ch);
    return (s == IND_CHARGING) ? ch : (s == IND_LOW);
  endfunction

  // ****************************************************************
  // Stimulus
  // ****************************************************************
  initial begin
    seed = 32'h009f_b025;
    mismatches = 0;
    samples_checked = 0;
    reset_i = 1'b1;
    cmp = analog_cmp_t'(7'h08);
    {awaddr, araddr, awvalid, wvalid, bready, arvalid, rready} = '0;
    wdata = 32'h0000_0000;
    wstrb = 4'h0;
    step(5);
    reset_i <= 1'b0;
    step(2);
    `CHK("irq_n", 1'b1, irq_n)
    `CHK("hiz", 1'b0, hiz)
    `CHK("ind_oe", 1'b0, ind_oe)
    for (int i = 0; i < 5; i++) rdchk(offs[i], 32'h0000_0000);
    axi_rd(8'h14, rd, rsp);
    `CHK("unmapped rresp", AXI_SLVERR, rsp)
    `CHK("unmapped rdata", 32'h0000_0000, rd)
    axi_wr(8'h14, 32'h0000_0003, 4'hf, rsp);
    `CHK("unmapped bresp", AXI_SLVERR, rsp)
    wr(MASK_OFFSET, 32'h0000_001f);
    for (int i = 0; i < 12; i++) begin
      sel = 2'($random(seed));
      c = 1'($random(seed));
      wr(MODE_OFFSET, {30'h0, c, 1'b0});
      wr(CTRL_OFFSET, {30'h0, sel});
      step(3);
      `CHK("charging", c, chg)
      `CHK("ind_oe", ind_exp(sel, c), ind_oe)
      `CHK("ind", 1'b0, ind)
    end
    wr(MODE_OFFSET, 32'h0000_0002);
    wr(CTRL_OFFSET, 32'h0000_0001);
    axi_wr(CTRL_OFFSET, 32'h0000_0002, 4'h0, rsp);
    rdchk(CTRL_OFFSET, 32'h0000_0001);
    // Boost-only comparators except start minimum asserted during charge
    cmp <= analog_cmp_t'(7'h6e);
    step(8);
    `CHK("charging", 1'b1, chg)
    `CHK("hiz", 1'b0, hiz)
    rdchk(STATUS_OFFSET, 32'h0000_0000);
    cmp <= analog_cmp_t'(7'h10);
    step(6);
    `CHK("charging", 1'b0, chg)
    `CHK("irq_n", 1'b0, irq_n)
    rdchk(STATUS_OFFSET, 32'h0000_0004);
    cmp <= analog_cmp_t'(7'h08);
    step(6);
    `CHK("charging", 1'b1, chg)
    `CHK("irq_n", 1'b1, irq_n)
    `CHK("ind_oe", 1'b1, ind_oe)
    rdchk(CTRL_OFFSET, 32'h0000_0000);
    rdchk(MASK_OFFSET, 32'h0000_0000);
    rdchk(MODE_OFFSET, 32'h0000_0002);
    wr(STATUS_OFFSET, 32'h0000_0004);
    rdchk(STATUS_OFFSET, 32'h0000_0000);
    for (int k = 0; k < 4; k++) begin
      wr(MODE_OFFSET, 32'h0000_0000);
      wr(MASK_OFFSET, 32'h0000_001f);
      if (k == 3) cmp <= analog_cmp_t'(fv[k]);
      wr(MODE_OFFSET, 32'h0000_0001);
      step(6);
      if (k < 3) begin
        `CHK("switching", 1'b1, sw)
        `CHK("charging", 1'b0, chg)
        cmp <= analog_cmp_t'(fv[k]);
        step(6);
      end
      `CHK("switching", 1'b0, sw)
      `CHK("hiz", 1'b1, hiz)
      `CHK("irq_n", 1'b0, irq_n)
      rdchk(STATUS_OFFSET, fb[k]);
      cmp <= analog_cmp_t'(7'h08);
      step(6);
      `CHK("hiz held", 1'b1, hiz)
      wr(STATUS_OFFSET, 32'h0000_001f);
    end
    wr(MODE_OFFSET, 32'h0000_0000);
    wr(MODE_OFFSET, 32'h0000_0001);
    wr(CTRL_OFFSET, 32'h0000_0001);
    wr(MASK_OFFSET, 32'h0000_001f);
    cmp <= analog_cmp_t'(7'h28);
    step(2000);
    cmp <= analog_cmp_t'(7'h08);
    step(4);
    rdchk(STATUS_OFFSET, 32'h0000_0000);
    cmp <= analog_cmp_t'(7'h28);
    step(int'(OVL_TEST) - 20);
    `CHK("switching", 1'b1, sw)
    rdchk(STATUS_OFFSET, 32'h0000_0000);
    step(40);
    `CHK("switching", 1'b0, sw)
    rdchk(STATUS_OFFSET, 32'h0000_0002);
    rdchk(MODE_OFFSET, 32'h0000_0000);
    rdchk(CTRL_OFFSET, 32'h0000_0000);
    rdchk(MASK_OFFSET, 32'h0000_0000);
    cmp <= analog_cmp_t'(7'h08);
    wrap_up();
  end
endmodule
